// ### ubs_pkg.sv
// shared constants for the uart baud select and control block
package ubs_pkg;
    // register offsets
    localparam logic [7:0] SERIAL_CONTROL_OFS = 8'h98;
    localparam logic [7:0] BAUD_RELOAD_OFS = 8'h9a;
    localparam logic [7:0] BAUD_CONTROL_OFS = 8'h9b;
    localparam logic [7:0] TIMER2_CONTROL_OFS = 8'hc8;
    localparam logic [7:0] POWER_CONTROL_OFS = 8'h87;
    localparam logic [7:0] SBUF_OFS = 8'h99;
    localparam logic [7:0] IRQ_STATUS_OFS = 8'he0;
    localparam logic [7:0] IRQ_MASK_OFS = 8'he1;
    localparam logic [7:0] LINE_STATUS_OFS = 8'he2;
    // serial_control fields
    localparam int SC_BIT7 = 7;
    localparam int SC_MODE1 = 6;
    localparam int SC_MP = 5;
    localparam int SC_REN = 4;
    localparam int SC_TB8 = 3;
    localparam int SC_RB8 = 2;
    localparam int SC_TI = 1;
    localparam int SC_RI = 0;
    // baud_control fields
    localparam int BC_TXGEN = 3;
    localparam int BC_RXGEN = 2;
    localparam int BC_FAST = 1;
    localparam int BC_M0GEN = 0;
    // timer2_control fields
    localparam int T2_RXSEL = 5;
    localparam int T2_TXSEL = 4;
    // power_control fields
    localparam int PC_DOUBLE = 7;
    localparam int PC_FEACC = 6;
    // irq status bits
    localparam int IRQ_TX = 0;
    localparam int IRQ_RX = 1;
    localparam int IRQ_FE = 2;
    // reset values
    localparam logic [7:0] SERIAL_CONTROL_RST = 8'h00;
    localparam logic [7:0] REG_RST = 8'h00;
    // timing counts
    localparam logic [3:0] UART_OVERSAMPLE = 4'hf;
    localparam logic [3:0] BIT_SAMPLE_POINT = 4'h7;
    localparam logic [3:0] MODE0_DIV12 = 4'hb;
    localparam logic [3:0] MODE0_DIV6 = 4'h5;
    localparam logic [1:0] FIXED_DIV = 2'h1;
    localparam logic [2:0] SLOW_PRESCALE = 3'h5;
    typedef enum logic [1:0] {UBS_SHIFT, UBS_UART8, UBS_UART9F, UBS_UART9V} ubs_mode_e;
endpackage : ubs_pkg

// ### ubs_baud_gen.sv
// internal reload baud generator with optional divide by 6
`timescale 1ns/1ps
module ubs_baud_gen
    import ubs_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic [7:0] reload_i,
    input wire logic fast_i,
    output logic tick_o
);
    typedef struct packed {
        logic [2:0] pre;
        logic [7:0] cnt;
        logic tick;
    } ubs_bg_s;
    ubs_bg_s st_r, st_nxt;

    always_comb begin
        logic step;
        step = 1'b0;
        st_nxt = st_r;
        st_nxt.tick = 1'b0;
        if (fast_i) begin
            step = 1'b1;
            st_nxt.pre = 3'h0;
        end else if (st_r.pre == SLOW_PRESCALE) begin
            step = 1'b1;
            st_nxt.pre = 3'h0;
        end else begin
            st_nxt.pre = st_r.pre + 3'h1;
        end
        if (step) begin
            if (st_r.cnt == 8'hff) begin
                st_nxt.cnt = reload_i;
                st_nxt.tick = 1'b1;
            end else begin
                st_nxt.cnt = st_r.cnt + 8'h01;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tick_o = st_r.tick;
endmodule : ubs_baud_gen

// ### ubs_sync.sv
// two flip-flop synchroniser for one level
`timescale 1ns/1ps
module ubs_sync
    import ubs_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic d_i,
    output logic q_o
);
    typedef struct packed {
        logic s1;
        logic s2;
    } ubs_sy_s;
    ubs_sy_s st_r, st_nxt;

    always_comb begin
        st_nxt.s1 = d_i;
        st_nxt.s2 = st_r.s1;
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_r <= 2'b11;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign q_o = st_r.s2;
endmodule : ubs_sync

// ### ubs_top.sv
// uart baud select, serial control register and serial engine
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
module ubs_top
    import ubs_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic t1_ovf_i,
    input wire logic t2_ovf_i,
    input wire logic double_speed_cpu_mode_i,
    input wire logic rxd_i,
    output logic rxd_o,
    output logic rxd_oe_o,
    output logic txd_o,
    output logic irq_o
);
    typedef struct packed {
        logic fe;
        logic sm0;
        logic [7:0] serial_control;
        logic [7:0] reload;
        logic [7:0] bdr;
        logic [7:0] t2c;
        logic [7:0] power_control;
        logic [7:0] txbuf;
        logic [7:0] rxbuf;
        logic [2:0] ists;
        logic [2:0] imask;
        logic [7:0] rdata;
        // transmitter
        logic tbusy;
        logic [3:0] tbit;
        logic [3:0] tsub;
        logic t1half;
        logic [9:0] tsh;
        logic txd;
        logic clk0;
        // receiver, then shift and fixed-rate prescalers, irq and drive enable
        logic rbusy;
        logic [3:0] rbit;
        logic [3:0] rsub;
        logic r1half;
        logic [8:0] rsh;
        logic rprev;
        logic [3:0] pre0;
        logic [1:0] fdiv;
        logic irq;
        logic oe;
    } ubs_st_s;
    ubs_st_s st_r, st_nxt;

    logic gen_tick;
    logic rxd_s;

    ubs_baud_gen u_gen (
        .mclk_i(mclk_i),
        .rst_b_i(rst_b_i),
        .reload_i(st_r.reload),
        .fast_i(st_r.bdr[BC_FAST]),
        .tick_o(gen_tick)
    );

    ubs_sync u_rx_sync (
        .mclk_i(mclk_i),
        .rst_b_i(rst_b_i),
        .d_i(rxd_i),
        .q_o(rxd_s)
    );

    always_comb begin
        ubs_mode_e mode;
        logic tx_src, rx_src, tx_tick, rx_tick, m0_tick, fix_tick;
        logic set_ti, set_ri, set_fe, rb8_ld, rb8_val, done;
        logic [3:0] m0_div;
        logic [7:0] sc_rd;
        st_nxt = st_r;
        mode = UBS_SHIFT;
        tx_src = 1'b0;
        rx_src = 1'b0;
        tx_tick = 1'b0;
        rx_tick = 1'b0;
        m0_tick = 1'b0;
        fix_tick = 1'b0;
        m0_div = 4'h0;
        sc_rd = 8'h00;
        set_ti = 1'b0;
        set_ri = 1'b0;
        set_fe = 1'b0;
        rb8_ld = 1'b0;
        rb8_val = 1'b0;
        done = 1'b0;
        mode = ubs_mode_e'({st_r.sm0, st_r.serial_control[SC_MODE1]});
        // source selection for modes 1 and 3
        if (st_r.bdr[BC_TXGEN]) tx_src = gen_tick;
        else if (st_r.t2c[T2_TXSEL]) tx_src = t2_ovf_i;
        else tx_src = t1_ovf_i;
        if (st_r.bdr[BC_RXGEN]) rx_src = gen_tick;
        else if (st_r.t2c[T2_RXSEL]) rx_src = t2_ovf_i;
        else rx_src = t1_ovf_i;
        // shift mode: fixed clock/12 (clock/6 in double speed) or generator
        m0_div = double_speed_cpu_mode_i ? MODE0_DIV6 : MODE0_DIV12;
        if (st_r.pre0 == m0_div) st_nxt.pre0 = 4'h0;
        else st_nxt.pre0 = st_r.pre0 + 4'h1;
        // two ticks per period, one for each half of the shift clock
        m0_tick = st_r.bdr[BC_M0GEN] ? gen_tick : (st_r.pre0 == m0_div || st_r.pre0 == (m0_div >> 1));
        // mode 2 fixed rate: clock/32 or /64 via 16x oversample
        st_nxt.fdiv = st_r.fdiv + 2'h1;
        fix_tick = st_r.power_control[PC_DOUBLE] ? (st_r.fdiv[0] == FIXED_DIV[0]) : (st_r.fdiv == FIXED_DIV);
        // halving of timer rate when not doubled
        tx_tick = 1'b0;
        rx_tick = 1'b0;
        unique case (mode)
            UBS_SHIFT: begin
                tx_tick = m0_tick;
                rx_tick = m0_tick;
            end
            UBS_UART9F: begin
                tx_tick = fix_tick;
                rx_tick = fix_tick;
            end
            UBS_UART8, UBS_UART9V: begin
                tx_tick = tx_src && (st_r.power_control[PC_DOUBLE] || st_r.t1half);
                rx_tick = rx_src && (st_r.power_control[PC_DOUBLE] || st_r.r1half);
                if (tx_src) st_nxt.t1half = ~st_r.t1half;
                if (rx_src) st_nxt.r1half = ~st_r.r1half;
            end
        endcase
        // transmitter
        if (st_r.tbusy && tx_tick) begin
            if (mode == UBS_SHIFT) begin
                // shift clock on txd: low half, then rising edge where data is taken
                st_nxt.clk0 = ~st_r.clk0;
                st_nxt.txd = st_r.clk0;
                if (st_r.clk0) begin
                    st_nxt.tbit = st_r.tbit + 4'h1;
                    if (st_r.tbit == 4'h7) begin
                        st_nxt.tbusy = 1'b0;
                        set_ti = 1'b1;
                    end
                end else if (st_r.tbit != 4'h0) begin
                    // next data bit moves out while the clock is low
                    st_nxt.tsh = {1'b1, st_r.tsh[9:1]};
                end
            end else begin
                st_nxt.tsub = st_r.tsub + 4'h1;
                if (st_r.tsub == UART_OVERSAMPLE) begin
                    st_nxt.tbit = st_r.tbit + 4'h1;
                    st_nxt.tsh = {1'b1, st_r.tsh[9:1]};
                    st_nxt.txd = st_r.tsh[0];
                    if ((mode == UBS_UART8 && st_r.tbit == 4'h9) || st_r.tbit == 4'ha) begin
                        set_ti = 1'b1;
                        st_nxt.txd = 1'b1;
                    end
                    if ((mode == UBS_UART8 && st_r.tbit == 4'ha) || st_r.tbit == 4'hb) begin
                        st_nxt.tbusy = 1'b0;
                    end
                end
            end
        end
        // receiver, shift mode drives the clock on txd and samples the data pin
        if (!st_r.serial_control[SC_REN]) begin
            st_nxt.rbusy = 1'b0;
        end else if (mode == UBS_SHIFT) begin
            if (!st_r.rbusy && !st_r.tbusy && !st_r.serial_control[SC_RI]) begin
                st_nxt.rbusy = 1'b1;
                st_nxt.rbit = 4'h0;
                st_nxt.clk0 = 1'b0;
            end else if (st_r.rbusy && rx_tick) begin
                st_nxt.clk0 = ~st_r.clk0;
                st_nxt.txd = st_r.clk0;
                if (st_r.clk0) begin
                    st_nxt.rsh = {1'b0, rxd_s, st_r.rsh[7:1]};
                    st_nxt.rbit = st_r.rbit + 4'h1;
                    if (st_r.rbit == 4'h7) begin
                        st_nxt.rbusy = 1'b0;
                        st_nxt.rxbuf = {rxd_s, st_r.rsh[7:1]};
                        set_ri = 1'b1;
                    end
                end
            end
        end else if (!st_r.rbusy) begin
            if (st_r.rprev && !rxd_s) begin
                st_nxt.rbusy = 1'b1;
                st_nxt.rbit = 4'h0;
                st_nxt.rsub = 4'h0;
            end
        end else if (rx_tick) begin
            st_nxt.rsub = st_r.rsub + 4'h1;
            if (st_r.rsub == BIT_SAMPLE_POINT) begin
                st_nxt.rbit = st_r.rbit + 4'h1;
                if (st_r.rbit == 4'h0 && rxd_s) st_nxt.rbusy = 1'b0;
                else if (st_r.rbit != 4'h0) st_nxt.rsh = {rxd_s, st_r.rsh[8:1]};
                // last data bit (mode 1: 8, modes 2/3: 9)
                if (!st_r.power_control[PC_FEACC] && st_r.rbit == (mode == UBS_UART8 ? 4'h8 : 4'h9)) begin
                    done = 1'b1;
                    rb8_val = (mode == UBS_UART8) ? 1'b1 : rxd_s;
                end
                // stop bit
                if (st_r.rbit == (mode == UBS_UART8 ? 4'h9 : 4'ha)) begin
                    st_nxt.rbusy = 1'b0;
                    if (!rxd_s && st_r.power_control[PC_FEACC]) set_fe = 1'b1;
                    if (st_r.power_control[PC_FEACC]) begin
                        done = 1'b1;
                        rb8_val = (mode == UBS_UART8) ? rxd_s : st_r.rsh[8];
                    end
                end
            end
        end
        if (done) begin
            // last data bit is still on the line when done comes without error check
            if (mode == UBS_UART8 && !st_r.power_control[PC_FEACC]) st_nxt.rxbuf = {rxd_s, st_r.rsh[8:2]};
            else if (mode != UBS_UART8 && st_r.power_control[PC_FEACC]) st_nxt.rxbuf = st_r.rsh[7:0];
            else st_nxt.rxbuf = st_r.rsh[8:1];
            if (!(st_r.serial_control[SC_MP] && !rb8_val)) begin
                set_ri = 1'b1;
                rb8_ld = (mode != UBS_UART8) || !st_r.serial_control[SC_MP] || 1'b1;
            end
        end
        st_nxt.rprev = rxd_s;
        // register writes
        if (wr_i) begin
            unique case (addr_i)
                SERIAL_CONTROL_OFS: begin
                    st_nxt.serial_control = wdata_i;
                    if (st_r.power_control[PC_FEACC]) st_nxt.fe = wdata_i[SC_BIT7];
                    else st_nxt.sm0 = wdata_i[SC_BIT7];
                end
                BAUD_RELOAD_OFS: st_nxt.reload = wdata_i;
                BAUD_CONTROL_OFS: st_nxt.bdr = {4'h0, wdata_i[3:0]};
                TIMER2_CONTROL_OFS: st_nxt.t2c = wdata_i;
                POWER_CONTROL_OFS: st_nxt.power_control = wdata_i;
                SBUF_OFS: begin
                    if (!st_r.tbusy) begin
                        st_nxt.tbusy = 1'b1;
                        st_nxt.tbit = 4'h0;
                        st_nxt.tsub = 4'h0;
                        st_nxt.clk0 = 1'b0;
                        if (mode == UBS_SHIFT) begin
                            st_nxt.tsh = {2'b11, wdata_i};
                        end else if (mode == UBS_UART8) begin
                            st_nxt.tsh = {1'b1, wdata_i, 1'b0};
                        end else begin
                            st_nxt.tsh = {st_r.serial_control[SC_TB8], wdata_i, 1'b0};
                        end
                    end
                end
                IRQ_STATUS_OFS: st_nxt.ists = st_r.ists & ~wdata_i[2:0];
                IRQ_MASK_OFS: st_nxt.imask = wdata_i[2:0];
                default: begin
                end
            endcase
        end
        // hardware sets win over software clears
        if (set_ti) st_nxt.serial_control[SC_TI] = 1'b1;
        if (set_ri) st_nxt.serial_control[SC_RI] = 1'b1;
        if (rb8_ld) st_nxt.serial_control[SC_RB8] = rb8_val;
        if (set_fe) st_nxt.fe = 1'b1;
        st_nxt.ists = st_nxt.ists | {set_fe, set_ri, set_ti};
        st_nxt.irq = |(st_nxt.ists & st_nxt.imask);
        st_nxt.oe = st_nxt.tbusy && ({st_nxt.sm0, st_nxt.serial_control[SC_MODE1]} == 2'b00);
        // read data one cycle later
        sc_rd = {st_r.power_control[PC_FEACC] ? st_r.fe : st_r.sm0, st_r.serial_control[6:0]};
        st_nxt.rdata = 8'h00;
        if (rd_i) begin
            unique case (addr_i)
                SERIAL_CONTROL_OFS: st_nxt.rdata = sc_rd;
                BAUD_RELOAD_OFS: st_nxt.rdata = st_r.reload;
                BAUD_CONTROL_OFS: st_nxt.rdata = st_r.bdr;
                TIMER2_CONTROL_OFS: st_nxt.rdata = st_r.t2c;
                POWER_CONTROL_OFS: st_nxt.rdata = st_r.power_control;
                SBUF_OFS: st_nxt.rdata = st_r.rxbuf;
                IRQ_STATUS_OFS: st_nxt.rdata = {5'h00, st_r.ists};
                IRQ_MASK_OFS: st_nxt.rdata = {5'h00, st_r.imask};
                LINE_STATUS_OFS: st_nxt.rdata = {6'h00, st_r.rbusy, st_r.tbusy};
                default: st_nxt.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_r <= '0;
            st_r.txd <= 1'b1;
            st_r.rprev <= 1'b1;
            st_r.tsh <= 10'h3ff;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rdata_o = st_r.rdata;
    assign txd_o = st_r.txd;
    assign irq_o = st_r.irq;
    assign rxd_o = st_r.tsh[0];
    assign rxd_oe_o = st_r.oe;
endmodule : ubs_top

// ### ubs_top_assertions.sv
// port checker for the uart baud select block
`timescale 1ns/1ps
module ubs_top_assertions
    import ubs_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic rxd_oe_o,
    input wire logic txd_o,
    input wire logic irq_o
);
    logic [7:0] sc_r, rel_r, msk_r, ra_r;
    logic fea_r, rv_r, mz_r, mm_r;
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            {sc_r, rel_r, msk_r, ra_r} <= 32'h0;
            {fea_r, rv_r, mz_r, mm_r} <= 4'h2;
        end else begin
            rv_r <= rd_i;
            ra_r <= addr_i;
            mz_r <= msk_r[2:0] == 3'h0;
            mm_r <= sc_r[7] | sc_r[6];
            if (wr_i && addr_i == SERIAL_CONTROL_OFS) sc_r <= {fea_r ? sc_r[7] : wdata_i[7], wdata_i[6:0]};
            if (wr_i && addr_i == BAUD_RELOAD_OFS) rel_r <= wdata_i;
            if (wr_i && addr_i == IRQ_MASK_OFS) msk_r <= wdata_i;
            if (wr_i && addr_i == POWER_CONTROL_OFS) fea_r <= wdata_i[PC_FEACC];
        end
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);
    a_rdata_idle: assert property (!rv_r |-> rdata_o == 8'h00) else $error("read data outside answer");
    a_unmapped_read: assert property (rv_r && ra_r == 8'h00 |-> rdata_o == 8'h00) else $error("unmapped read");
    a_reload_read: assert property (rv_r && ra_r == BAUD_RELOAD_OFS |-> rdata_o == rel_r)
        else $error("reload readback");
    a_ctl_read: assert property (rv_r && ra_r == SERIAL_CONTROL_OFS |-> rdata_o[6:3] == sc_r[6:3])
        else $error("control readback");
    a_mode_bit0: assert property (rv_r && ra_r == SERIAL_CONTROL_OFS && !fea_r |-> rdata_o[7] == sc_r[7])
        else $error("mode bit 0 readback");
    a_irq_masked: assert property (mz_r && msk_r[2:0] == 3'h0 |-> !irq_o) else $error("masked irq");
    a_oe_uart: assert property (mm_r && (sc_r[7] | sc_r[6]) |-> !rxd_oe_o) else $error("drive in uart mode");
    a_tx_start: assert property (wr_i && addr_i == SBUF_OFS && sc_r[6] |-> ##[1:400] !txd_o)
        else $error("no start bit");
    a_tx_return: assert property ($fell(txd_o) |-> ##[1:1000] txd_o) else $error("line stuck low");
    cover property ($fell(txd_o));
    cover property ($rose(irq_o));
    cover property ($rose(rxd_oe_o));
    cover property (rv_r && ra_r == SERIAL_CONTROL_OFS && fea_r);
endmodule : ubs_top_assertions
bind ubs_top ubs_top_assertions chk_u (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rxd_oe_o(rxd_oe_o), .txd_o(txd_o), .irq_o(irq_o));

// ### ubs_peer.sv
// remote serial node model on the uart line
`timescale 1ns/1ps
module ubs_peer (
    input wire logic mclk_i,
    input wire logic txd_i,
    input wire logic data_i,
    output logic rxd_o
);
    int bit_cyc = 64;
    logic nine = 1'b0;
    logic [8:0] got_q[$];
    logic shift = 1'b0;
    logic [7:0] sh = 8'h00;
    int sh_n = 0;
    time t0 = 0, t1 = 0;
    initial rxd_o = 1'b1;
    // shift mode: data taken at each rising edge of the clock on txd
    always @(posedge txd_i) begin
        if (shift) begin
            sh = {data_i, sh[7:1]};
            if (sh_n == 0) t0 = $time;
            t1 = $time;
            sh_n++;
        end
    end
    task automatic send(input logic [7:0] d, input logic b8, input logic stop);
        logic [10:0] f;
        f = nine ? {stop, b8, d, 1'b0} : {1'b1, stop, d, 1'b0};
        @(posedge mclk_i);
        for (int i = 0; i < 11; i++) begin
            rxd_o <= f[i];
            repeat (bit_cyc) @(posedge mclk_i);
        end
    endtask : send
    // samples mid-bit: eight data bits then ninth or stop
    always begin : cap
        logic [8:0] r;
        @(negedge txd_i iff !shift);
        repeat (bit_cyc / 2) @(posedge mclk_i);
        for (int i = 0; i < 9; i++) begin
            repeat (bit_cyc) @(posedge mclk_i);
            r[i] = txd_i;
        end
        got_q.push_back(r);
    end
endmodule : ubs_peer

// ### tb_top.sv
// self-checking bench for the uart baud select block
`timescale 1ns/1ps
module tb_top
    import ubs_pkg::*;
;
    logic mclk_i = 1'b0, rst_b_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, t1_ovf_i = 1'b0, t2_ovf_i = 1'b0;
    logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o, v;
    logic rxd_o, rxd_oe_o, txd_o, irq_o, peer_rxd;
    logic x2 = 1'b0;
    logic [31:0] seed = 32'h5399003d;
    int errors = 0, checked = 0, src = 0, cyc = 0, n;
    int srcs[4] = '{1, 2, 0, 1};
    logic [7:0] t2c[4] = '{8'h00, 8'h30, 8'h00, 8'h00};
    logic [7:0] bdc[4] = '{8'h00, 8'h00, 8'h0e, 8'h0a};
    logic [8:0] exp_q[$];
    always #12.5 mclk_i = ~mclk_i;
    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        t1_ovf_i <= src == 1 && cyc % 4 == 0;
        t2_ovf_i <= src == 2 && cyc % 4 == 0;
    end
    ubs_top dut_u (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .t1_ovf_i(t1_ovf_i), .t2_ovf_i(t2_ovf_i), .double_speed_cpu_mode_i(x2),
        .rxd_i(rxd_oe_o ? rxd_o : peer_rxd), .rxd_o(rxd_o), .rxd_oe_o(rxd_oe_o), .txd_o(txd_o), .irq_o(irq_o));
    ubs_peer peer_u (.mclk_i(mclk_i), .txd_i(txd_o), .data_i(rxd_o), .rxd_o(peer_rxd));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs
    task automatic results(input bit hang);
        if (hang) begin
            errors++;
            $display("BAD %0t: wait ran out", $time);
        end
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : results
    task automatic chk(input logic [8:0] seen, input logic [8:0] exp, input string msg);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %0t: %s saw %h want %h", $time, msg, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge mclk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        @(negedge mclk_i);
        v = rdata_o;
    endtask : rd
    task automatic tx(input logic [8:0] e);
        exp_q.push_back(e);
        wr(SBUF_OFS, e[7:0]);
        for (n = 0; n < 3000 && peer_u.got_q.size() == 0; n++) @(posedge mclk_i);
        if (n == 3000) results(1);
        chk(peer_u.got_q.pop_front(), exp_q.pop_front(), "tx frame");
        repeat (2 * peer_u.bit_cyc) @(posedge mclk_i);
    endtask : tx
    task automatic rx(input logic [7:0] d, input logic b8, input logic stop);
        peer_u.send(d, b8, stop);
        for (n = 0; n < 3000 && irq_o !== 1'b1; n++) @(posedge mclk_i);
        if (n == 3000) results(1);
    endtask : rx
    initial begin
        repeat (2) @(posedge mclk_i);
        rst_b_i <= 1'b1;
        rd(SERIAL_CONTROL_OFS);
        chk(v, SERIAL_CONTROL_RST, "control reset");
        rd(8'h00);
        chk(v, 8'h00, "unmapped read");
        wr(POWER_CONTROL_OFS, 8'h80);
        wr(IRQ_MASK_OFS, 8'h07);
        wr(BAUD_RELOAD_OFS, 8'hfc);
        wr(SERIAL_CONTROL_OFS, 8'h50);
        for (int k = 0; k < 4; k++) begin
            src = srcs[k];
            wr(TIMER2_CONTROL_OFS, t2c[k]);
            wr(BAUD_CONTROL_OFS, bdc[k]);
            seed = xs(seed);
            tx({1'b1, seed[7:0]});
            rd(IRQ_STATUS_OFS);
            chk(v[IRQ_TX], 1'b1, "tx done");
            wr(IRQ_STATUS_OFS, 8'h07);
            rx(seed[15:8], 1'b0, 1'b1);
            rd(SBUF_OFS);
            chk(v, seed[15:8], "rx byte");
            rd(SERIAL_CONTROL_OFS);
            chk(v[2:0], 3'h7, "rb8 ti ri");
            wr(SERIAL_CONTROL_OFS, 8'h50);
            wr(IRQ_STATUS_OFS, 8'h07);
        end
        $display("test source select done");
        src = 0;
        wr(POWER_CONTROL_OFS, 8'h00);
        wr(BAUD_CONTROL_OFS, 8'h0c);
        wr(BAUD_RELOAD_OFS, 8'hff);
        peer_u.bit_cyc = 192;
        tx(9'h1a5);
        $display("test slow rate done");
        peer_u.bit_cyc = 64;
        peer_u.nine = 1'b1;
        wr(POWER_CONTROL_OFS, 8'h80);
        wr(BAUD_CONTROL_OFS, 8'h0e);
        wr(BAUD_RELOAD_OFS, 8'hfc);
        wr(SERIAL_CONTROL_OFS, 8'hd8);
        tx(9'h13c);
        for (int b = 0; b < 2; b++) begin
            wr(IRQ_STATUS_OFS, 8'h07);
            rx(8'h5a, b[0], 1'b1);
            rd(SERIAL_CONTROL_OFS);
            chk(v[2], b[0], "ninth bit in");
        end
        $display("test nine bit done");
        peer_u.nine = 1'b0;
        wr(SERIAL_CONTROL_OFS, 8'h50);
        wr(POWER_CONTROL_OFS, 8'hc0);
        for (int s = 0; s < 2; s++) begin
            wr(IRQ_STATUS_OFS, 8'h07);
            rx(8'h33, 1'b0, s[0]);
            rd(SERIAL_CONTROL_OFS);
            chk(v[7], 1'b1, "framing error sticky");
        end
        wr(SERIAL_CONTROL_OFS, 8'h50);
        rd(SERIAL_CONTROL_OFS);
        chk(v[7], 1'b0, "framing error cleared");
        wr(POWER_CONTROL_OFS, 8'h80);
        wr(SERIAL_CONTROL_OFS, 8'hd0);
        rd(SERIAL_CONTROL_OFS);
        chk(v[7], 1'b1, "mode bit 0");
        $display("test framing done");
        wr(SERIAL_CONTROL_OFS, 8'h40);
        wr(IRQ_STATUS_OFS, 8'h07);
        wr(IRQ_MASK_OFS, 8'h00);
        peer_u.send(8'h66, 1'b0, 1'b1);
        tx(9'h199);
        @(negedge mclk_i);
        chk(irq_o, 1'b0, "masked irq");
        rd(IRQ_STATUS_OFS);
        chk(v[2:0], 3'h1, "rx off tx done");
        wr(IRQ_MASK_OFS, 8'h01);
        repeat (2) @(negedge mclk_i);
        chk(irq_o, 1'b1, "irq on");
        wr(IRQ_STATUS_OFS, 8'h01);
        repeat (2) @(negedge mclk_i);
        chk(irq_o, 1'b0, "irq cleared");
        $display("test receiver off and irq done");
        peer_u.shift = 1'b1;
        for (int x = 0; x < 2; x++) begin
            wr(SERIAL_CONTROL_OFS, 8'h00);
            x2 <= x[0];
            peer_u.sh_n = 0;
            seed = xs(seed);
            wr(SBUF_OFS, seed[7:0]);
            for (n = 0; n < 3000 && peer_u.sh_n < 8; n++) @(posedge mclk_i);
            if (n == 3000) results(1);
            chk(peer_u.sh, seed[7:0], "shift byte");
            chk(9'((peer_u.t1 - peer_u.t0) / 25), 9'(7 * ((x ? MODE0_DIV6 : MODE0_DIV12) + 1)), "shift rate");
            rd(SERIAL_CONTROL_OFS);
            chk(v[SC_TI], 1'b1, "shift tx done");
        end
        $display("test shift mode done");
        results(0);
    end
endmodule : tb_top
